//--- hdl/pwdg_defines.svh
`ifndef PWDG_DEFINES_SVH
`define PWDG_DEFINES_SVH

// ****************************************************************
// register addresses (byte addresses on the cpu bus)
// ****************************************************************
`define PWDG_ADDR_CNT_CTL_WR 16'hfeec
`define PWDG_ADDR_CTL_RD     16'hfeec
`define PWDG_ADDR_CNT_RD     16'hfeed
`define PWDG_ADDR_RST_WR     16'hff14
`define PWDG_ADDR_RST_RD     16'hff15

// ****************************************************************
// passwords carried in the upper byte of a word write
// ****************************************************************
`define PWDG_PASS_A 8'h5a
`define PWDG_PASS_B 8'ha5
`define PWDG_CLR_DATA 8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define PWDG_CTL_OVF_BIT  7
`define PWDG_CTL_MODE_BIT 6
`define PWDG_CTL_RUN_BIT  5
`define PWDG_RST_FLAG_BIT 7
`define PWDG_RST_OE_BIT   6

// ****************************************************************
// reset values and fixed read-as-one masks
// ****************************************************************
`define PWDG_CNT_RESET    8'h00
`define PWDG_CTL_ONES     8'h18
`define PWDG_RST_ONES     8'h3f

// ****************************************************************
// timing
// ****************************************************************
`define PWDG_RST_PULSE_CYC 132
`define PWDG_CNT_W         8

`endif

//--- hdl/pwdg_pkg.sv
package pwdg_pkg;

  // state of the reset pulse generator, gray along idle->pulse
  typedef enum logic [0:0] {
    PWDG_PULSE_IDLE = 1'b0,
    PWDG_PULSE_LOW  = 1'b1
  } pwdg_pulse_t;

  // decoded write target
  typedef enum logic [2:0] {
    PWDG_WR_NONE  = 3'h0,
    PWDG_WR_CNT   = 3'h1,
    PWDG_WR_CTL   = 3'h2,
    PWDG_WR_RSTCL = 3'h3,
    PWDG_WR_RESET_OUTPUT_ENABLE = 3'h4
  } pwdg_wr_t;

endpackage

//--- hdl/pwdg_prescaler.sv
`timescale 1ns/1ps
// run-gated prescaler giving one-cycle tick pulses at the selected division
module pwdg_prescaler (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // control
  input  wire logic       run_i,
  input  wire logic [2:0] sel_i,
  output logic            tick_o
);

  logic [11:0] div_q;
  logic [11:0] mask;

  // divide ratios 2,32,64,128,256,512,2048,4096 by code
  always_comb begin
    unique case (sel_i)
      3'h0: mask = 12'h001;
      3'h1: mask = 12'h01f;
      3'h2: mask = 12'h03f;
      3'h3: mask = 12'h07f;
      3'h4: mask = 12'h0ff;
      3'h5: mask = 12'h1ff;
      3'h6: mask = 12'h7ff;
      3'h7: mask = 12'hfff;
    endcase
  end

  // held clear while stopped so the first tick lands a full period after start
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= 12'h000;
    end else if (!run_i) begin
      div_q <= 12'h000;
    end else begin
      div_q <= div_q + 12'h001;
    end
  end

  assign tick_o = run_i && ((div_q & mask) == mask);

endmodule // pwdg_prescaler

//--- hdl/pwdg_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for one level from a pin
module pwdg_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // level
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= 1'b1;
      q_o    <= 1'b1;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule // pwdg_sync

//--- hdl/pwdg_top.sv
`timescale 1ns/1ps
`include "pwdg_defines.svh"
// Summary of operation
// - while running, the count steps once per selected prescaler tick.
// - interval mode wrap from ff to 00 sets overflow flag; watchdog mode does not.
// - count is zero and stopped on reset and while run enable is 0.
// - overflow flag clears on standby or by writing 0 after reading 1; 1 never sets.
// - control bit 6 selects interval (0, reset value) or watchdog (1) mode.
// - overflow while running gives chip reset or interval interrupt by mode.
// - control bits 4 and 3 ignore writes and read as 1.
// - divider codes 0..7 give clock/2,32,64,128,256,512,2048,4096.
// - control bits 7..5 clear on reset and standby; bits 2..0 only on reset.
// - watchdog mode overflow sets the reset flag and resets the chip.
// - reset flag clears on pin reset or software 0 after read 1.
// - reset output enable 1 drives the watchdog reset low on the pin.
// - reset output enable survives watchdog reset, clears on pin reset.
// - reset control bits 5..0 ignore writes and read as 1.
// - counter and control are written only by word writes.
// - shared write address; 5a routes low byte to counter, a5 to control.
// - reset control register updates only on a word write.
// - a5 with data 00 at reset control address clears the reset flag once it was read as 1.
// - 5a at reset control address copies data bit 6 to output enable.
// - byte reads: control at shared address, counter next, reset control own.
// - enabled external reset output is a low pulse of 132 clocks.
// - a counter write in the same cycle as a tick wins, tick skipped.
module pwdg_top (
  // clock and reset (resetn_i is the power-on/pin reset of this block)
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // cpu bus
  input  wire logic [15:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic        word_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        rd_i,
  output logic [7:0]       rdata_o,
  // system
  input  wire logic        standby_i,
  input  wire logic        ext_reset_pin_n_i,
  // outputs
  output logic             interval_irq_o,
  output logic             chip_reset_o,
  output logic             reset_pin_o,
  output logic             reset_pin_oe_o
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0]          count_q;
  logic                ovf_q;
  logic                ovf_seen_q;
  logic                mode_q;
  logic                run_q;
  logic [2:0]          sel_q;
  logic                wflag_q;
  logic                wflag_seen_q;
  logic                rst_oe_q;
  logic                pin_n_s;
  logic                tick;
  logic                wrap;
  logic [7:0]          ctl_rd;
  logic [7:0]          rst_rd;
  logic [7:0]          wlo;
  logic [7:0]          whi;
  pwdg_pkg::pwdg_wr_t  wsel;
  pwdg_pkg::pwdg_pulse_t pstate_q;
  logic [7:0]          pcnt_q;

  assign wlo = wdata_i[7:0];
  assign whi = wdata_i[15:8];

  // ****************************************************************
  // pin synchroniser and prescaler
  // ****************************************************************
  pwdg_sync u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (ext_reset_pin_n_i),
    .q_o      (pin_n_s)
  );

  pwdg_prescaler u_presc (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .run_i    (run_q),
    .sel_i    (sel_q),
    .tick_o   (tick)
  );

  // ****************************************************************
  // write decode
  // ****************************************************************
  // byte writes and unknown passwords decode to nothing
  always_comb begin
    wsel = pwdg_pkg::PWDG_WR_NONE;
    if (wr_i && word_i) begin
      if (addr_i == `PWDG_ADDR_CNT_CTL_WR) begin
        if (whi == `PWDG_PASS_A) begin
          wsel = pwdg_pkg::PWDG_WR_CNT;
        end else if (whi == `PWDG_PASS_B) begin
          wsel = pwdg_pkg::PWDG_WR_CTL;
        end
      end else if (addr_i == `PWDG_ADDR_RST_WR) begin
        if (whi == `PWDG_PASS_B && wlo == `PWDG_CLR_DATA) begin
          wsel = pwdg_pkg::PWDG_WR_RSTCL;
        end else if (whi == `PWDG_PASS_A) begin
          wsel = pwdg_pkg::PWDG_WR_RESET_OUTPUT_ENABLE;
        end
      end
    end
  end

  // ****************************************************************
  // counter
  // ****************************************************************
  assign wrap = tick && (count_q == 8'hff) && (wsel != pwdg_pkg::PWDG_WR_CNT);

  // write beats tick; stopped counter is held at zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_q <= `PWDG_CNT_RESET;
    end else if (!run_q) begin
      count_q <= `PWDG_CNT_RESET;
    end else if (wsel == pwdg_pkg::PWDG_WR_CNT) begin
      count_q <= wlo;
    end else if (tick) begin
      count_q <= count_q + 8'h01;
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  // mode and run clear on standby entry; divider select keeps its value
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= 1'b0;
      run_q  <= 1'b0;
      sel_q  <= 3'h0;
    end else if (standby_i) begin
      mode_q <= 1'b0;
      run_q  <= 1'b0;
    end else if (wsel == pwdg_pkg::PWDG_WR_CTL) begin
      mode_q <= wlo[`PWDG_CTL_MODE_BIT];
      run_q  <= wlo[`PWDG_CTL_RUN_BIT];
      sel_q  <= wlo[2:0];
    end
  end

  // overflow flag: read-as-one arms the clear, set wins over clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovf_q      <= 1'b0;
      ovf_seen_q <= 1'b0;
    end else if (wrap && !mode_q) begin
      ovf_q      <= 1'b1;
    end else if (standby_i) begin
      ovf_q      <= 1'b0;
      ovf_seen_q <= 1'b0;
    end else if (wsel == pwdg_pkg::PWDG_WR_CTL && !wlo[`PWDG_CTL_OVF_BIT] && ovf_seen_q) begin
      ovf_q      <= 1'b0;
      ovf_seen_q <= 1'b0;
    end else if (rd_i && addr_i == `PWDG_ADDR_CTL_RD && ovf_q) begin
      ovf_seen_q <= 1'b1;
    end
  end

  // ****************************************************************
  // reset control register
  // ****************************************************************
  // pin reset clears both bits; a watchdog reset leaves the output enable alone
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wflag_q      <= 1'b0;
      wflag_seen_q <= 1'b0;
    end else if (wrap && mode_q) begin
      wflag_q      <= 1'b1;
    end else if (!pin_n_s && pstate_q == pwdg_pkg::PWDG_PULSE_IDLE) begin
      wflag_q      <= 1'b0;
      wflag_seen_q <= 1'b0;
    end else if (wsel == pwdg_pkg::PWDG_WR_RSTCL && wflag_seen_q) begin
      wflag_q      <= 1'b0;
      wflag_seen_q <= 1'b0;
    end else if (rd_i && addr_i == `PWDG_ADDR_RST_RD && wflag_q) begin
      wflag_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_oe_q <= 1'b0;
    end else if (!pin_n_s && pstate_q == pwdg_pkg::PWDG_PULSE_IDLE) begin
      rst_oe_q <= 1'b0;
    end else if (wsel == pwdg_pkg::PWDG_WR_RESET_OUTPUT_ENABLE) begin
      rst_oe_q <= wlo[`PWDG_RST_OE_BIT];
    end
  end

  // ****************************************************************
  // watchdog reset pulse
  // ****************************************************************
  // the pulse drives our own pin low, so the pin is ignored while it runs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pstate_q <= pwdg_pkg::PWDG_PULSE_IDLE;
      pcnt_q   <= 8'h00;
    end else begin
      unique case (pstate_q)
        pwdg_pkg::PWDG_PULSE_IDLE: begin
          if (wrap && mode_q) begin
            pstate_q <= pwdg_pkg::PWDG_PULSE_LOW;
            pcnt_q   <= 8'(`PWDG_RST_PULSE_CYC - 1);
          end
        end
        pwdg_pkg::PWDG_PULSE_LOW: begin
          if (pcnt_q == 8'h00) begin
            pstate_q <= pwdg_pkg::PWDG_PULSE_IDLE;
          end else begin
            pcnt_q <= pcnt_q - 8'h01;
          end
        end
      endcase
    end
  end

  assign chip_reset_o   = (pstate_q == pwdg_pkg::PWDG_PULSE_LOW);
  assign reset_pin_o    = 1'b0;
  assign reset_pin_oe_o = chip_reset_o && rst_oe_q;

  // interval interrupt is a one-cycle pulse per overflow
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      interval_irq_o <= 1'b0;
    end else begin
      interval_irq_o <= wrap && !mode_q;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  assign ctl_rd = {ovf_q, mode_q, run_q, 2'b00, sel_q} | `PWDG_CTL_ONES;
  assign rst_rd = {wflag_q, rst_oe_q, 6'h00} | `PWDG_RST_ONES;

  // registered byte read; unmapped reads return zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        `PWDG_ADDR_CTL_RD: rdata_o <= ctl_rd;
        `PWDG_ADDR_CNT_RD: rdata_o <= count_q;
        `PWDG_ADDR_RST_RD: rdata_o <= rst_rd;
        default:           rdata_o <= 8'h00;
      endcase
    end
  end

endmodule // pwdg_top

//--- test/pwdg_cpu_model.sv
`timescale 1ns/1ps
// ****
// cpu side of the register bus
// ****
module pwdg_cpu_model (
  // clock
  input  wire logic       clk_i,
  // bus
  output logic [15:0]     addr_o,
  output logic            wr_o,
  output logic            word_o,
  output logic [15:0]     wdata_o,
  output logic            rd_o,
  input  wire logic [7:0] rdata_i
);
  // idle bus at time zero
  initial begin
    addr_o = 16'h0000;
    wr_o = 1'b0;
    word_o = 1'b0;
    wdata_o = 16'h0000;
    rd_o = 1'b0;
  end
  // one write; released lines show the inverse so stale values never pass as valid
  task automatic write(input logic [15:0] a, input logic w, input logic [15:0] v);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= v;
    word_o <= w;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~v;
  endtask
  // one byte read, data taken the cycle after the strobe
  task automatic read(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    v = rdata_i;
  endtask
endmodule  // pwdg_cpu_model

//--- test/pwdg_monitor.sv
`timescale 1ns/1ps
`include "pwdg_defines.svh"
// ****
// port checker
// ****
module pwdg_monitor (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        resetn_i,
  // cpu bus
  input wire logic [15:0] addr_i,
  input wire logic        wr_i,
  input wire logic        word_i,
  input wire logic [15:0] wdata_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  // system and outputs
  input wire logic        standby_i,
  input wire logic        ext_reset_pin_n_i,
  input wire logic        interval_irq_o,
  input wire logic        chip_reset_o,
  input wire logic        reset_pin_o,
  input wire logic        reset_pin_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [8:0] len_q;
  // length of the running reset pulse, zero between pulses
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      len_q <= 9'h000;
    end else begin
      len_q <= chip_reset_o ? len_q + 9'h001 : 9'h000;
    end
  end
  // pin is only pulled low inside a reset pulse
  a_oe_in_pulse: assert property (reset_pin_oe_o |-> chip_reset_o)
    else $error("pin enable outside reset pulse");
  a_pin_low: assert property (reset_pin_oe_o |-> !reset_pin_o)
    else $error("pin driven high");
  a_pulse_len: assert property ($fell(chip_reset_o) |-> len_q == 9'h084)
    else $error("reset pulse too short");
  a_pulse_max: assert property (chip_reset_o |-> len_q < 9'h084)
    else $error("reset pulse too long");
  a_irq_single: assert property (interval_irq_o |=> !interval_irq_o)
    else $error("interrupt pulse longer than one cycle");
  a_ctl_ones: assert property (rd_i && addr_i == `PWDG_ADDR_CTL_RD |=> rdata_o[4:3] == 2'b11)
    else $error("control fixed bits not one");
  a_rst_ones: assert property (rd_i && addr_i == `PWDG_ADDR_RST_RD |=> rdata_o[5:0] == 6'h3f)
    else $error("reset control fixed bits not one");
  a_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data changed without a read");
  // main scenarios
  c_irq: cover property (interval_irq_o);
  c_pulse_out: cover property ($rose(chip_reset_o) && reset_pin_oe_o);
  c_rst_read: cover property (rd_i && addr_i == `PWDG_ADDR_RST_RD);
endmodule  // pwdg_monitor

bind pwdg_top pwdg_monitor u_mon (
  .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_i(wr_i), .word_i(word_i),
  .wdata_i(wdata_i), .rd_i(rd_i), .rdata_o(rdata_o), .standby_i(standby_i),
  .ext_reset_pin_n_i(ext_reset_pin_n_i), .interval_irq_o(interval_irq_o),
  .chip_reset_o(chip_reset_o), .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o)
);

//--- test/tb.sv
`timescale 1ns/1ps
`include "pwdg_defines.svh"
module tb;
  // ****
  // bench signals
  // ****
  logic        clk_i;
  logic        resetn_i;
  logic        standby;
  logic        ext_n;
  logic [15:0] addr;
  logic        wr;
  logic        word;
  logic [15:0] wdata;
  logic        rd;
  logic [7:0]  rdata;
  logic        irq;
  logic        crst;
  logic        pin;
  logic        oe_pin;
  logic [7:0]  c0;
  logic [7:0]  c1;
  int          err_count;
  int          n_checks;
  int          div [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  pwdg_cpu_model u_cpu (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .word_o(word), .wdata_o(wdata),
    .rd_o(rd), .rdata_i(rdata));
  pwdg_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr), .wr_i(wr), .word_i(word),
    .wdata_i(wdata), .rd_i(rd), .rdata_o(rdata), .standby_i(standby), .ext_reset_pin_n_i(ext_n),
    .interval_irq_o(irq), .chip_reset_o(crst), .reset_pin_o(pin), .reset_pin_oe_o(oe_pin));
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string what);
    logic [7:0] v;
    u_cpu.read(a, v);
    check(what, v, e);
  endtask
  task automatic wr_w(input logic [15:0] a, input logic [15:0] v);
    u_cpu.write(a, 1'b1, v);
  endtask
  // bounded wait for interrupt (1) or chip reset (0)
  task automatic wait_for(input logic sel);
    int i;
    i = 0;
    while ((sel ? irq : crst) !== 1'b1) begin
      @(posedge clk_i);
      #1;
      i++;
      if (i > 3000) begin
        err_count++;
        end_sim();
      end
    end
  endtask
  // overflow in watchdog mode from a count near the top, then time the pulse
  task automatic pulse(input logic oe);
    int n;
    logic bad;
    n = 0;
    bad = 1'b0;
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'ha560);
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'h5afe);
    wait_for(1'b0);
    while (crst === 1'b1 && n < 300) begin
      if (oe_pin !== oe || (oe_pin === 1'b1 && pin !== 1'b0)) bad = 1'b1;
      n++;
      @(posedge clk_i);
      #1;
    end
    check("pulse length", n[7:0], 8'h84);
    check("pin enable", {7'h00, bad}, 8'h00);
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'ha500);
  endtask
  initial begin
    clk_i = 1'b0;
    resetn_i = 1'b0;
    standby = 1'b0;
    ext_n = 1'b1;
    err_count = 0;
    n_checks = 0;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    rchk(`PWDG_ADDR_CTL_RD, 8'h18, "ctl reset");
    rchk(`PWDG_ADDR_CNT_RD, 8'h00, "cnt reset");
    rchk(`PWDG_ADDR_RST_RD, 8'h3f, "rst reset");
    rchk(16'hfeee, 8'h00, "unmapped");
    // refused writes: byte access, bad password, counter while stopped
    u_cpu.write(`PWDG_ADDR_CNT_CTL_WR, 1'b0, 16'ha525);
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'h3325);
    rchk(`PWDG_ADDR_CTL_RD, 8'h18, "ctl refused");
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'h5a44);
    rchk(`PWDG_ADDR_CNT_RD, 8'h00, "cnt stopped");
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'ha5bf);
    rchk(`PWDG_ADDR_CTL_RD, 8'h3f, "ctl write");
    // counting rate for every divider code
    for (int c = 0; c < 8; c++) begin
      wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'ha500);
      wr_w(`PWDG_ADDR_CNT_CTL_WR, {8'ha5, 5'b00100, c[2:0]});
      u_cpu.read(`PWDG_ADDR_CNT_RD, c0);
      repeat (8 * div[c] - 3) @(posedge clk_i);
      u_cpu.read(`PWDG_ADDR_CNT_RD, c1);
      check("ticks", c1 - c0, 8'h08);
    end
    // interval overflow; flag clears only after it was read as one
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'ha520);
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'h5afe);
    wait_for(1'b1);
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'ha520);
    rchk(`PWDG_ADDR_CTL_RD, 8'hb8, "ovf set");
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'ha520);
    rchk(`PWDG_ADDR_CTL_RD, 8'h38, "ovf clear");
    // watchdog overflow with the pin output enabled
    wr_w(`PWDG_ADDR_RST_WR, 16'h5a40);
    rchk(`PWDG_ADDR_RST_RD, 8'h7f, "oe set");
    u_cpu.write(`PWDG_ADDR_RST_WR, 1'b0, 16'h5a00);
    rchk(`PWDG_ADDR_RST_RD, 8'h7f, "rst byte");
    pulse(1'b1);
    rchk(`PWDG_ADDR_RST_RD, 8'hff, "wd flag");
    rchk(`PWDG_ADDR_CTL_RD, 8'h18, "no ovf in wd");
    wr_w(`PWDG_ADDR_RST_WR, 16'ha501);
    rchk(`PWDG_ADDR_RST_RD, 8'hff, "bad clear");
    // pin reset clears flag and output enable
    @(posedge clk_i);
    ext_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    ext_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    rchk(`PWDG_ADDR_RST_RD, 8'h3f, "pin reset");
    // second overflow kept internal, then cleared by software
    pulse(1'b0);
    rchk(`PWDG_ADDR_RST_RD, 8'hbf, "wd flag 2");
    wr_w(`PWDG_ADDR_RST_WR, 16'ha500);
    rchk(`PWDG_ADDR_RST_RD, 8'h3f, "sw clear");
    // standby clears mode (run already 0) but keeps the divider
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'ha547);
    rchk(`PWDG_ADDR_CTL_RD, 8'h5f, "ctl mode");
    @(posedge clk_i);
    standby <= 1'b1;
    @(posedge clk_i);
    standby <= 1'b0;
    rchk(`PWDG_ADDR_CTL_RD, 8'h1f, "standby");
    // restart at divide by 2: the counter write lands on the first tick
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'ha520);
    wr_w(`PWDG_ADDR_CNT_CTL_WR, 16'h5a10);
    rchk(`PWDG_ADDR_CNT_RD, 8'h10, "write beats tick");
    end_sim();
  end
endmodule  // tb
